// >>> src/emi_bank_regs.sv
// The four bank configuration registers with a registered read port
`timescale 1ns/1ns
`default_nettype none
module emi_bank_regs
   import emi_pkg::*;
(
   // Clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   // Write port
   input  wire logic                      wrEn,
   input  wire logic [1:0]                wrIndex,
   input  wire logic [15:0]               wrData,
   // Read port
   input  wire logic [1:0]                rdIndex,
   output logic [15:0]                    rdData,
   // Configuration seen by the access engine
   output bank_cfg_t [BANKS-1:0]          cfg
);

   typedef struct packed {
      bank_cfg_t [BANKS-1:0] cfg;
      logic [15:0]           rdData;
   } regs_state_t;

   regs_state_t cur_ff;
   regs_state_t nxt_regs;

   always_comb begin
      nxt_regs = cur_ff;
      // Reserved bits are not stored and read back as zero
      if (wrEn) begin
         nxt_regs.cfg[wrIndex] = bank_cfg_t'(wrData & CFG_RW_MASK); // R19 R18
      end
      nxt_regs.rdData = 16'(cur_ff.cfg[rdIndex]); // R19
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < BANKS; i++) begin
            cur_ff.cfg[i] <= bank_cfg_t'(CFG_RESET[i]); // R20
         end
         cur_ff.rdData <= '0;
      end else begin
         cur_ff <= nxt_regs;
      end
   end

   assign cfg    = cur_ff.cfg;
   assign rdData = cur_ff.rdData;

endmodule : emi_bank_regs
`default_nettype wire

// >>> src/emi_pkg.sv
// Constants, field layouts and carrier types of the external memory interface
package emi_pkg;

   // External bus geometry
   localparam int EXT_ADDR_W = 24;
   localparam int EXT_DATA_W = 16;
   localparam int BANKS      = 4;

   // Memory map of the four banks and of the configuration registers
   localparam logic [BANKS-1:0][31:0] BANK_BASE = {32'h6600_0000, 32'h6400_0000,
                                                   32'h6200_0000, 32'h6000_0000};
   localparam logic [31:0] BANK_MASK  = 32'hFF00_0000;
   localparam logic [31:0] REG_BASE   = 32'h6C00_0000;
   localparam logic [31:0] REG_MASK   = 32'hFFFF_FFF0;
   localparam int          REG_IDX_LSB = 2;

   // Register byte offsets, one aligned word each
   localparam logic [7:0] BANK0_CONFIG_OFS = 8'h00;
   localparam logic [7:0] BANK1_CONFIG_OFS = 8'h04;
   localparam logic [7:0] BANK2_CONFIG_OFS = 8'h08;
   localparam logic [7:0] BANK3_CONFIG_OFS = 8'h0C;

   // Bank configuration register layout
   typedef struct packed {
      logic       bankOn;
      logic [8:0] reserved;
      logic [3:0] cycleLength;
      logic [1:0] busSize;
   } bank_cfg_t;

   localparam logic [BANKS-1:0][15:0] CFG_RESET = {16'h003C, 16'h003E, 16'h003D, 16'h803D};
   localparam logic [15:0]            CFG_RW_MASK = 16'h803F;

   // Bus size codes
   localparam logic [1:0] BUS_8  = 2'h0;
   localparam logic [1:0] BUS_16 = 2'h1;

   // Chip-select length beyond the wait states
   localparam logic [4:0] WRITE_EXTRA = 5'h01;
   localparam logic [4:0] READ_EXTRA  = 5'h02;

   // AHB-Lite encodings
   localparam int         HTRANS_ACTIVE_BIT = 1;
   localparam logic [1:0] HSIZE_BYTE = 2'h0;
   localparam logic [1:0] HSIZE_HALF = 2'h1;
   localparam logic [1:0] HSIZE_WORD = 2'h2;

   typedef enum logic [2:0] {IDLE, SETUP, ACTIVE, GAP, REG} emi_state_t;

   // External memory pins
   typedef struct packed {
      logic [EXT_ADDR_W-1:0] addr;
      logic [BANKS-1:0]      bankSelectN;
      logic                  readStrobeN;
      logic [1:0]            writeStrobeN;
      logic [EXT_DATA_W-1:0] dataOut;
      logic                  dataOeN;
   } mem_pins_t;

   localparam mem_pins_t PINS_IDLE = '{addr: '0, bankSelectN: '1, readStrobeN: 1'b1,
                                       writeStrobeN: '1, dataOut: '0, dataOeN: 1'b1};

endpackage : emi_pkg

// >>> src/emi_wait_counter.sv
// Down counter that times one chip-select period
`timescale 1ns/1ns
`default_nettype none
module emi_wait_counter
   import emi_pkg::*;
#(
   parameter int W = 5
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] loadValue,
   // Status
   output logic              expired
);

   typedef struct packed {
      logic [W-1:0] count;
   } cnt_state_t;

   cnt_state_t cur_ff;
   cnt_state_t nxt_cnt;

   if (W < 5) begin : g_check
      $error("emi_wait_counter: W too small for the longest period");
   end

   always_comb begin
      nxt_cnt = cur_ff;
      if (load) begin
         nxt_cnt.count = loadValue;
      end else if (cur_ff.count != '0) begin
         nxt_cnt.count = cur_ff.count - W'(1);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cnt;
      end
   end

   assign expired = (cur_ff.count == '0);

endmodule : emi_wait_counter
`default_nettype wire

// >>> src/external_memory_interface.sv
// External static memory interface: AHB-Lite slave, four banks, 16-bit external bus
//
// How it works
// R1: Each bank gets a 24-bit external address, 16 MByte per bank.
// R2: One active-low chip select per bank; only the addressed bank's is asserted.
// R3: Banks decode at 0x6000_0000, 0x6200_0000, 0x6400_0000 and 0x6600_0000.
// R4: Active-low read strobe is the output enable; reads never pulse write strobes.
// R5: Two active-low write strobes: lower for bits 7:0, upper for bits 15:8.
// R6: Bank 0 always runs as a 16-bit bus whatever its size field says.
// R7: Bus-size field 00 means 8-bit, 01 means 16-bit; 10 and 11 reserved.
// R8: Cycle-length field in bits 5:2 inserts 0 to 15 wait states.
// R9: A single read holds chip select for cycle length plus two clocks.
// R10: A single write holds chip select for cycle length plus one clock.
// R11: An access split into N external cycles takes N single-cycle lengths; split writes here add one gap clock between cycles.
// R12: Whole access lasts internal length plus total chip-select length.
// R13: Halfword write to 16-bit bank: one cycle, both strobes, low address unchanged.
// R14: Word write to 8-bit bank: four cycles, address low bits 00..11, lower strobe.
// R15: Chip select stays low over all partial writes; strobe rises one clock between.
// R16: Word read from 16-bit bank: low half held, full word returned after second.
// R17: Split word read on 16-bit bus drives address bits 1:0 as 00 then 10.
// R18: Bit 15 of a bank register enables the bank when set.
// R19: Four 16-bit read/write bank registers in the internal register area.
// R20: Reset values 0x803D, 0x003D, 0x003E, 0x003C; only bank 0 enabled.
// R21: Byte write to 16-bit bank strobes only the lane chosen by address bit 0.
`timescale 1ns/1ns
`default_nettype none
module external_memory_interface
   import emi_pkg::*;
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // AHB-Lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic [31:0]                hrdata,
   // External memory bus
   output mem_pins_t                  memPins,
   input  wire logic [EXT_DATA_W-1:0] memDataIn
);

   typedef struct packed {
      emi_state_t            state;
      logic                  hreadyout;
      logic                  hresp;
      logic [31:0]           hrdata;
      logic                  write;
      logic [1:0]            size;
      logic                  wide;
      logic [1:0]            bank;
      logic [3:0]            cycleLength;
      logic [EXT_ADDR_W-1:0] base;
      logic [1:0]            part;
      logic [1:0]            lastPart;
      logic [31:0]           buffer;
      mem_pins_t             pins;
   } emi_main_t;

   emi_main_t             cur_ff;
   emi_main_t             nxt_main;

   bank_cfg_t [BANKS-1:0] cfg;
   logic [15:0]           regRdData;
   logic                  regWrEn;
   logic                  waitLoad;
   logic [4:0]            waitValue;
   logic                  waitDone;
   logic                  accept;
   logic                  hitBank;
   logic [1:0]            hitIdx;
   logic                  hitReg;

   // Number of external cycles, less one, that one transfer needs
   function automatic logic [1:0] lastPartOf(input logic [1:0] size, input logic wide);
      logic [1:0] n;
      n = 2'h0;
      if (wide) begin
         if (size == HSIZE_WORD) begin
            n = 2'h1; // R16
         end
      end else begin
         unique case (size)
            HSIZE_WORD: n = 2'h3; // R14 R11
            HSIZE_HALF: n = 2'h1;
            default:    n = 2'h0;
         endcase
      end
      return n;
   endfunction : lastPartOf

   // Byte lane (8-bit bus) or half lane (16-bit bus) of the word for one partial cycle
   function automatic logic [1:0] laneOf(input emi_main_t s);
      logic [1:0] lane;
      if (s.wide) begin
         lane = {1'b0, s.base[1] ^ s.part[0]};
      end else begin
         lane = s.base[1:0] + s.part;
      end
      return lane;
   endfunction : laneOf

   // Chip-select period of one partial cycle, less one, for the wait counter
   function automatic logic [4:0] periodOf(input emi_main_t s);
      logic [4:0] len;
      len = 5'(s.cycleLength) + (s.write ? WRITE_EXTRA : READ_EXTRA); // R8 R9 R10
      return len - 5'h01;
   endfunction : periodOf

   // Pin levels for the current partial cycle
   function automatic mem_pins_t drivePins(input emi_main_t s);
      mem_pins_t  p;
      logic [1:0] lane;
      p    = PINS_IDLE;
      lane = laneOf(s);
      p.bankSelectN[s.bank] = 1'b0; // R2
      p.readStrobeN         = s.write; // R4
      p.dataOeN             = ~s.write;
      if (s.wide) begin
         p.addr    = {s.base[EXT_ADDR_W-1:2], lane[0], s.base[0]}; // R13 R17
         p.dataOut = s.buffer[16*lane[0] +: 16];
      end else begin
         p.addr    = {s.base[EXT_ADDR_W-1:2], lane}; // R14
         p.dataOut = {8'h00, s.buffer[8*lane +: 8]};
      end
      if (s.write) begin
         if (!s.wide) begin
            p.writeStrobeN = 2'b10; // R14
         end else if (s.size == HSIZE_BYTE) begin
            p.writeStrobeN = s.base[0] ? 2'b01 : 2'b10; // R21 R5
         end else begin
            p.writeStrobeN = 2'b00; // R13 R5
         end
      end
      return p;
   endfunction : drivePins

   // Read data of the current partial cycle merged into the word
   function automatic logic [31:0] mergeRead(input emi_main_t s, input logic [15:0] din);
      logic [31:0] w;
      logic [1:0]  lane;
      w    = s.buffer;
      lane = laneOf(s);
      if (s.wide) begin
         w[16*lane[0] +: 16] = din; // R16
      end else begin
         w[8*lane +: 8] = din[7:0];
      end
      return w;
   endfunction : mergeRead

   // Address decode of the address phase
   always_comb begin
      hitBank = 1'b0;
      hitIdx  = 2'h0;
      for (int b = 0; b < BANKS; b++) begin
         if ((haddr & BANK_MASK) == BANK_BASE[b]) begin // R3
            hitBank = 1'b1;
            hitIdx  = 2'(b);
         end
      end
      hitReg = ((haddr & REG_MASK) == REG_BASE);
      accept = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
   end

   always_comb begin
      nxt_main  = cur_ff;
      regWrEn   = 1'b0;
      waitLoad  = 1'b0;
      waitValue = '0;
      unique case (cur_ff.state)
         IDLE: begin
            if (accept) begin
               nxt_main.hrdata = '0;
               nxt_main.write  = hwrite;
               nxt_main.size   = hsize[1:0];
               nxt_main.part   = 2'h0;
               if (hitBank && cfg[hitIdx].bankOn) begin // R18
                  nxt_main.state       = SETUP;
                  nxt_main.hreadyout   = 1'b0;
                  nxt_main.bank        = hitIdx;
                  nxt_main.base        = haddr[EXT_ADDR_W-1:0]; // R1
                  nxt_main.cycleLength = cfg[hitIdx].cycleLength; // R8
                  // Bank 0 ignores its size field; reserved codes fall back to 8-bit
                  nxt_main.wide        = (hitIdx == 2'h0) || (cfg[hitIdx].busSize == BUS_16); // R6 R7
                  nxt_main.lastPart    = lastPartOf(hsize[1:0], nxt_main.wide);
               end else if (hitReg) begin
                  nxt_main.state     = REG;
                  nxt_main.hreadyout = 1'b0;
                  nxt_main.bank      = haddr[REG_IDX_LSB +: 2];
               end
            end
         end
         SETUP: begin
            // Internal access cycle: write data is only valid in the data phase
            if (cur_ff.write) begin
               nxt_main.buffer = hwdata;
            end
            nxt_main.pins  = drivePins(nxt_main); // R12
            nxt_main.state = ACTIVE;
            waitLoad       = 1'b1;
            waitValue      = periodOf(cur_ff);
         end
         ACTIVE: begin
            if (waitDone) begin
               if (!cur_ff.write) begin
                  nxt_main.buffer = mergeRead(cur_ff, memDataIn); // R16
               end
               if (cur_ff.part == cur_ff.lastPart) begin
                  nxt_main.pins      = PINS_IDLE;
                  nxt_main.state     = IDLE;
                  nxt_main.hreadyout = 1'b1;
                  nxt_main.hrdata    = cur_ff.write ? '0 : nxt_main.buffer; // R16
               end else begin
                  nxt_main.part = cur_ff.part + 2'h1; // R11
                  if (cur_ff.write) begin
                     // Chip select and data stay while the strobe rises for one clock
                     nxt_main.pins.writeStrobeN = '1; // R15
                     nxt_main.state             = GAP;
                  end else begin
                     nxt_main.pins = drivePins(nxt_main); // R17
                     waitLoad      = 1'b1;
                     waitValue     = periodOf(cur_ff);
                  end
               end
            end
         end
         GAP: begin
            nxt_main.pins  = drivePins(cur_ff); // R15 R14
            nxt_main.state = ACTIVE;
            waitLoad       = 1'b1;
            waitValue      = periodOf(cur_ff);
         end
         REG: begin
            regWrEn            = cur_ff.write; // R19
            nxt_main.hrdata    = cur_ff.write ? '0 : {16'h0000, regRdData};
            nxt_main.hreadyout = 1'b1;
            nxt_main.state     = IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur_ff.state       <= IDLE;
         cur_ff.hreadyout   <= 1'b1;
         cur_ff.hresp       <= 1'b0;
         cur_ff.hrdata      <= '0;
         cur_ff.write       <= 1'b0;
         cur_ff.size        <= HSIZE_BYTE;
         cur_ff.wide        <= 1'b1;
         cur_ff.bank        <= 2'h0;
         cur_ff.cycleLength <= '0;
         cur_ff.base        <= '0;
         cur_ff.part        <= 2'h0;
         cur_ff.lastPart    <= 2'h0;
         cur_ff.buffer      <= '0;
         cur_ff.pins        <= PINS_IDLE;
      end else begin
         cur_ff <= nxt_main;
      end
   end

   emi_bank_regs u_regs (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wrEn    (regWrEn),
      .wrIndex (cur_ff.bank),
      .wrData  (hwdata[15:0]),
      .rdIndex (haddr[REG_IDX_LSB +: 2]),
      .rdData  (regRdData),
      .cfg     (cfg)
   );

   // Times each chip-select period so the engine only watches one flag
   emi_wait_counter #(.W(5)) u_wait (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .load      (waitLoad),
      .loadValue (waitValue),
      .expired   (waitDone)
   );

   assign hreadyout = cur_ff.hreadyout;
   assign hresp     = cur_ff.hresp;
   assign hrdata    = cur_ff.hrdata;
   assign memPins   = cur_ff.pins;

endmodule : external_memory_interface
`default_nettype wire

// >>> tb/emi_mem_model.sv
// Behavioural external memory on all four chip selects
`timescale 1ns/1ns
`default_nettype none
module emi_mem_model
   import emi_pkg::*;
#(
   parameter logic [3:0] WIDE = 4'b0011
) (
   // Clock
   input  wire logic      ref_clk,
   // Pins from the device
   input  wire mem_pins_t memPins,
   output logic [15:0]    memDataIn
);
   logic [7:0]  mem [4][256];
   logic [1:0]  bank;
   logic [7:0]  a;
   logic [15:0] last = 16'h0000;
   logic        sel;

   initial begin
      foreach (mem[i, j]) mem[i][j] = 8'h00;
   end
   assign a   = memPins.addr[7:0];
   assign sel = !(&memPins.bankSelectN);
   always_comb begin
      bank = 2'h0;
      for (int b = 0; b < 4; b++) if (!memPins.bankSelectN[b]) bank = 2'(b);
   end
   // Released bus shows the inverse of the last value so a stale sample cannot match
   always_comb begin
      if (sel && !memPins.readStrobeN) begin
         if (WIDE[bank]) memDataIn = {mem[bank][{a[7:1], 1'b1}], mem[bank][{a[7:1], 1'b0}]};
         else memDataIn = {~last[15:8], mem[bank][a]};
      end else memDataIn = ~last;
   end
   always @(posedge ref_clk) begin
      last <= memDataIn;
      if (sel && !memPins.writeStrobeN[0]) mem[bank][WIDE[bank] ? {a[7:1], 1'b0} : a] <= memPins.dataOut[7:0];
      if (sel && !memPins.writeStrobeN[1]) mem[bank][{a[7:1], 1'b1}] <= memPins.dataOut[15:8];
   end
endmodule : emi_mem_model
`default_nettype wire

// >>> tb/external_memory_interface_bench.sv
// Self-checking bench: AHB-Lite master tasks driving the memory interface
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module external_memory_interface_bench;
   import emi_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0000_0000;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [2:0]  hsize   = 3'h0;
   logic [31:0] hwdata  = 32'h0000_0000;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   mem_pins_t   memPins;
   logic [15:0] memDataIn;
   logic [23:0] wrAddr;
   int          miscompares = 0;
   int          checked = 0;
   logic [15:0] rv [4] = '{16'h803D, 16'h003D, 16'h003E, 16'h003C};

   always #4 ref_clk = ~ref_clk;
   assign hready = hreadyout;
   always @(posedge ref_clk) if (memPins.writeStrobeN != 2'b11) wrAddr <= memPins.addr;

   external_memory_interface u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memPins(memPins), .memDataIn(memDataIn));
   emi_mem_model #(.WIDE(4'b0101)) u_mem (.ref_clk(ref_clk), .memPins(memPins), .memDataIn(memDataIn));

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict

   // One single transfer; counts data-phase wait cycles and checks them and any read data
   task automatic op(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d,
                     input int exCyc, input logic [31:0] exRd);
      int cyc;
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= s;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      cyc = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) begin
         cyc++;
         @(posedge ref_clk);
      end
      `CHK(cyc, exCyc)
      if (!w) `CHK(hrdata, exRd)
   endtask : op

   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) op(0, 32'h6C00_0000 + 32'(i * 4), 3'h2, 0, 1, {16'h0000, rv[i]});
      $display("test reset values done");
      op(1, 32'h6C00_0004, 3'h2, 32'hFFFF_FFFF, 1, 0);
      op(0, 32'h6C00_0004, 3'h2, 0, 1, 32'h0000_803F);
      op(1, 32'h6200_0000, 3'h2, 32'hCAFE_F00D, 1 + 4 * 16 + 3, 0);
      op(1, 32'h6C00_0004, 3'h1, 32'h0000_003D, 1, 0);
      op(0, 32'h6200_0000, 3'h2, 0, 0, 32'h0000_0000);
      op(0, 32'h6100_0000, 3'h2, 0, 0, 32'h0000_0000);
      op(0, 32'h6800_0000, 3'h2, 0, 0, 32'h0000_0000);
      $display("test enable and decode done");
      op(1, 32'h6C00_0000, 3'h2, 32'h0000_8004, 1, 0);
      op(1, 32'h6C00_0008, 3'h2, 32'h0000_800D, 1, 0);
      op(1, 32'h6C00_000C, 3'h2, 32'h0000_8000, 1, 0);
      op(1, 32'h6000_0010, 3'h2, 32'hA16F_2DDA, 1 + 2 * 2 + 1, 0);
      op(0, 32'h6000_0010, 3'h2, 0, 1 + 2 * 3, 32'hA16F_2DDA);
      `CHK(u_mem.mem[0][8'h12], 8'h6F)
      $display("test bank0 word done");
      op(1, 32'h6600_0020, 3'h2, 32'h1122_3344, 1 + 4 * 1 + 3, 0);
      `CHK(u_mem.mem[3][8'h20], 8'h44)
      `CHK(u_mem.mem[3][8'h23], 8'h11)
      op(0, 32'h6600_0020, 3'h2, 0, 1 + 4 * 2, 32'h1122_3344);
      op(1, 32'h66AB_CD07, 3'h0, 32'h5500_0000, 1 + 1, 0);
      `CHK(wrAddr, 24'hAB_CD07)
      $display("test narrow bank done");
      op(1, 32'h6400_0031, 3'h0, 32'h0000_BE00, 1 + 4, 0);
      `CHK(u_mem.mem[2][8'h31], 8'hBE)
      `CHK(u_mem.mem[2][8'h30], 8'h00)
      op(1, 32'h6400_0040, 3'h1, 32'h0000_5AC3, 1 + 4, 0);
      op(0, 32'h6400_0040, 3'h2, 0, 1 + 2 * 5, 32'h0000_5AC3);
      $display("test wide bank lanes done");
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      miscompares++;
      give_verdict();
   end
endmodule : external_memory_interface_bench
`undef CHK
`default_nettype wire

// >>> tb/external_memory_interface_chk.sv
// Port-level assertions of the external memory interface
`timescale 1ns/1ns
`default_nettype none
module external_memory_interface_chk
   import emi_pkg::*;
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // AHB-Lite
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   input  wire logic                  hreadyout,
   input  wire logic                  hresp,
   input  wire logic [31:0]           hrdata,
   // External bus
   input  wire mem_pins_t             memPins,
   input  wire logic [EXT_DATA_W-1:0] memDataIn
);
   logic acc;
   assign acc = hsel & htrans[1] & hready & hreadyout;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence oneWait;
      !hreadyout ##1 hreadyout;
   endsequence
   one_select_a: assert property ($onehot0(~memPins.bankSelectN)) else $error("two selects low");
   strobe_select_a: assert property ((!memPins.readStrobeN || memPins.writeStrobeN != 2'b11)
      |-> !(&memPins.bankSelectN)) else $error("strobe without select");
   read_only_a: assert property (!memPins.readStrobeN |-> memPins.writeStrobeN == 2'b11 && memPins.dataOeN)
      else $error("write strobe in read");
   write_drive_a: assert property (memPins.writeStrobeN != 2'b11 |-> !memPins.dataOeN)
      else $error("write without data drive");
   write_gap_a: assert property ($rose(&memPins.writeStrobeN) && !(&memPins.bankSelectN)
      |=> memPins.writeStrobeN != 2'b11) else $error("gap not one clock");
   addr_hold_a: assert property (memPins.writeStrobeN != 2'b11 && $past(memPins.writeStrobeN) != 2'b11
      |-> $stable(memPins.addr)) else $error("address moved in strobe");
   reg_wait_a: assert property (acc && (haddr & REG_MASK) == REG_BASE |=> oneWait)
      else $error("register wait wrong");
   unmapped_fast_a: assert property (acc && haddr[31:24] == 8'h61 |=> hreadyout && hrdata == 32'h0000_0000)
      else $error("unmapped not immediate");
   busy_bound_a: assert property (!hreadyout |-> ##[1:80] hreadyout) else $error("access too long");
   okay_resp_a: assert property (!hresp) else $error("response not okay");
endmodule : external_memory_interface_chk
bind external_memory_interface external_memory_interface_chk u_chk (.ref_clk(ref_clk), .rst(rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .memPins(memPins),
   .memDataIn(memDataIn));
`default_nettype wire
